// [epf_framer.sv]
// event poll response framer: header, payload chunk and integrity word
`timescale 1ns/100ps
module epf_framer
    import epf_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    input  wire logic        clk,         // 10 MHz clock
    input  wire logic        rst,         // synchronous reset, active high
    input  wire logic [31:0] buf_size,    // negotiated event buffer size
    input  wire logic        cmd_valid,   // response request offered
    output logic             cmd_ready,   // request taken when both high
    input  wire epf_cmd_t    cmd,         // response request fields
    input  wire logic [7:0]  pay_data,    // payload byte
    input  wire logic        pay_valid,   // payload byte offered
    output logic             pay_ready,   // payload byte taken
    output logic [7:0]       out_data,    // response byte
    output logic             out_last,    // last byte of response
    output logic             out_valid,   // response byte offered
    input  wire logic        out_ready,   // receiver takes byte
    output logic             len_err      // pulse: chunk too large, dropped
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // -----------------------------------------------------------------
    // output buffer
    // -----------------------------------------------------------------
    epf_byte_t         mem_r [DEPTH];
    logic [PW-1:0]     wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0]     cnt_r, cnt_nxt;
    logic              push, pop, fifo_ready;
    epf_byte_t         push_byte;

    assign fifo_ready = (cnt_r != CW'(DEPTH));
    assign out_valid  = (cnt_r != '0);
    assign out_data   = mem_r[rd_ptr_r].data;
    assign out_last   = mem_r[rd_ptr_r].last;
    assign pop        = out_valid && out_ready;

    always_comb
    begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        cnt_nxt    = cnt_r;
        if (push)
            wr_ptr_nxt = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
        if (pop)
            rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
        if (push && !pop)
            cnt_nxt = cnt_r + CW'(1);
        else if (pop && !push)
            cnt_nxt = cnt_r - CW'(1);
    end

    // entries are not reset; a receiver stall simply holds them
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r    <= cnt_nxt;
        end
        if (push)
            mem_r[wr_ptr_r] <= push_byte;
    end

    // -----------------------------------------------------------------
    // framing state
    // -----------------------------------------------------------------
    epf_state_t        state_r, state_nxt;
    logic [15:0]       id_r, id_nxt;
    logic [31:0]       handle_r, handle_nxt;
    logic [7:0]        flag_r, flag_nxt;
    logic [7:0]        cat_r, cat_nxt;
    logic [31:0]       len_r, len_nxt;
    logic [31:0]       left_r, left_nxt;
    logic              send_crc_r, send_crc_nxt;
    logic              pend_crc_r, pend_crc_nxt;
    logic [3:0]        idx_r, idx_nxt;
    logic [3:0]        hdr_last_r, hdr_last_nxt;
    logic [1:0]        crc_idx_r, crc_idx_nxt;
    logic [31:0]       crc_r, crc_nxt;
    logic              err_nxt;

    logic [15:0]       rep_id;
    logic              null_id, first, crc_only, want_crc, crc_over;
    logic [EPF_HDR_BITS-1:0] hdr_vec;
    logic [31:0]       crc_fin;

    assign hdr_vec   = {len_r, cat_r, flag_r, handle_r, id_r};
    assign crc_fin   = ~crc_r;
    assign cmd_ready = (state_r == EPF_IDLE);
    assign pay_ready = (state_r == EPF_PAY) && fifo_ready;

    always_comb
    begin
        rep_id = cmd.event_id;
        if (cmd.queue_empty)
            rep_id = EPF_ID_QUEUE_EMPTY;
        else if (cmd.op == EPF_OP_ACK_WITHOUT)
            rep_id = EPF_ID_ACK_PENDING;
        null_id  = (rep_id == EPF_ID_QUEUE_EMPTY) || (rep_id == EPF_ID_ACK_PENDING);
        first    = (cmd.op == EPF_OP_FETCH_INITIAL);
        crc_only = pend_crc_r && (cmd.op == EPF_OP_FETCH_FOLLOWING);
        want_crc = cmd.is_last && !first;
        // one spare bit so a huge chunk length cannot wrap the sum
        crc_over = ({1'b0, cmd.chunk_len} + {1'b0, EPF_CRC_BYTES}) > {1'b0, buf_size};
    end

    always_comb
    begin
        state_nxt    = state_r;
        id_nxt       = id_r;
        handle_nxt   = handle_r;
        flag_nxt     = flag_r;
        cat_nxt      = cat_r;
        len_nxt      = len_r;
        left_nxt     = left_r;
        send_crc_nxt = send_crc_r;
        pend_crc_nxt = pend_crc_r;
        idx_nxt      = idx_r;
        hdr_last_nxt = hdr_last_r;
        crc_idx_nxt  = crc_idx_r;
        crc_nxt      = crc_r;
        err_nxt      = 1'b0;
        push         = 1'b0;
        push_byte    = '0;
        unique case (state_r)
            EPF_IDLE:
            begin
                if (cmd_valid)
                begin
                    id_nxt       = rep_id;
                    handle_nxt   = cmd.next_handle;
                    cat_nxt      = cmd.category;
                    idx_nxt      = '0;
                    crc_idx_nxt  = '0;
                    hdr_last_nxt = null_id ? EPF_HDR_LAST_NULL
                                           : EPF_HDR_LAST_FULL;
                    if (first)
                    begin
                        crc_nxt      = EPF_CRC_PRESET;
                        pend_crc_nxt = 1'b0;
                    end
                    if (null_id)
                    begin
                        len_nxt      = '0;
                        send_crc_nxt = 1'b0;
                        state_nxt    = EPF_HDR;
                    end
                    else if (crc_only)
                    begin
                        len_nxt      = '0;
                        flag_nxt     = EPF_POS_FINAL;
                        send_crc_nxt = 1'b1;
                        pend_crc_nxt = 1'b0;
                        state_nxt    = EPF_HDR;
                    end
                    else if (cmd.chunk_len > buf_size)
                        err_nxt = 1'b1;
                    else
                    begin
                        len_nxt = cmd.chunk_len;
                        if (first && cmd.is_last)
                            flag_nxt = EPF_POS_SINGLE;
                        else if (first)
                            flag_nxt = EPF_POS_FIRST;
                        else if (cmd.is_last)
                            flag_nxt = EPF_POS_FINAL;
                        else
                            flag_nxt = EPF_POS_MIDDLE;
                        send_crc_nxt = want_crc;
                        if (want_crc && crc_over)
                        begin
                            flag_nxt     = EPF_POS_MIDDLE;
                            send_crc_nxt = 1'b0;
                            pend_crc_nxt = 1'b1;
                        end
                        state_nxt = EPF_HDR;
                    end
                    left_nxt = len_nxt;
                end
            end
            EPF_HDR:
            begin
                push_byte.data = hdr_vec[EPF_BYTE_W*idx_r +: EPF_BYTE_W];
                push_byte.last = (idx_r == hdr_last_r) && (len_r == '0) && !send_crc_r;
                if (fifo_ready)
                begin
                    push    = 1'b1;
                    idx_nxt = idx_r + 4'h1;
                    if (idx_r == hdr_last_r)
                    begin
                        if (len_r != '0)
                            state_nxt = EPF_PAY;
                        else if (send_crc_r)
                            state_nxt = EPF_CRC;
                        else
                            state_nxt = EPF_IDLE;
                    end
                end
            end
            EPF_PAY:
            begin
                push_byte.data = pay_data;
                push_byte.last = (left_r == EPF_ONE) && !send_crc_r;
                if (pay_valid && fifo_ready)
                begin
                    push     = 1'b1;
                    crc_nxt  = epf_crc_byte(crc_r, pay_data);
                    left_nxt = left_r - EPF_ONE;
                    if (left_r == EPF_ONE)
                        state_nxt = send_crc_r ? EPF_CRC : EPF_IDLE;
                end
            end
            EPF_CRC:
            begin
                // word never split: all four bytes go in this one response
                push_byte.data = crc_fin[EPF_BYTE_W*crc_idx_r +: EPF_BYTE_W];
                push_byte.last = (crc_idx_r == EPF_CRC_LAST_IDX);
                if (fifo_ready)
                begin
                    push        = 1'b1;
                    crc_idx_nxt = crc_idx_r + 2'h1;
                    if (crc_idx_r == EPF_CRC_LAST_IDX)
                        state_nxt = EPF_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r    <= EPF_IDLE;
            id_r       <= '0;
            handle_r   <= '0;
            flag_r     <= '0;
            cat_r      <= '0;
            len_r      <= '0;
            left_r     <= '0;
            send_crc_r <= 1'b0;
            pend_crc_r <= 1'b0;
            idx_r      <= '0;
            hdr_last_r <= '0;
            crc_idx_r  <= '0;
            crc_r      <= EPF_CRC_PRESET;
            len_err    <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            id_r       <= id_nxt;
            handle_r   <= handle_nxt;
            flag_r     <= flag_nxt;
            cat_r      <= cat_nxt;
            len_r      <= len_nxt;
            left_r     <= left_nxt;
            send_crc_r <= send_crc_nxt;
            pend_crc_r <= pend_crc_nxt;
            idx_r      <= idx_nxt;
            hdr_last_r <= hdr_last_nxt;
            crc_idx_r  <= crc_idx_nxt;
            crc_r      <= crc_nxt;
            len_err    <= err_nxt;
        end
    end

endmodule

// [epf_pkg.sv]
// constants, carriers and helpers for the event poll response framer
package epf_pkg;

    // -----------------------------------------------------------------
    // identifiers, flags and widths
    // -----------------------------------------------------------------
    localparam logic [15:0] EPF_ID_QUEUE_EMPTY = 16'h0000;
    localparam logic [15:0] EPF_ID_ACK_PENDING = 16'hFFFF;

    localparam logic [7:0]  EPF_POS_FIRST      = 8'h00;
    localparam logic [7:0]  EPF_POS_MIDDLE     = 8'h01;
    localparam logic [7:0]  EPF_POS_FINAL      = 8'h04;
    localparam logic [7:0]  EPF_POS_SINGLE     = 8'h05;

    localparam logic [7:0]  EPF_OP_FETCH_FOLLOWING = 8'h00;
    localparam logic [7:0]  EPF_OP_FETCH_INITIAL   = 8'h01;
    localparam logic [7:0]  EPF_OP_ACK_WITHOUT     = 8'h02;

    localparam logic [31:0] EPF_CRC_POLY_REFL  = 32'hEDB8_8320;
    localparam logic [31:0] EPF_CRC_PRESET     = 32'hFFFF_FFFF;
    localparam logic [31:0] EPF_CRC_BYTES      = 32'h0000_0004;
    localparam logic [1:0]  EPF_CRC_LAST_IDX   = 2'h3;

    localparam logic [3:0]  EPF_HDR_LAST_NULL  = 4'h1;
    localparam logic [3:0]  EPF_HDR_LAST_FULL  = 4'hB;
    localparam int          EPF_BYTE_W         = 8;
    localparam int          EPF_HDR_BITS       = 96;

    localparam logic [31:0] EPF_DEFAULT_BUF    = 32'h0000_0100;
    localparam logic [31:0] EPF_ONE            = 32'h0000_0001;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  op;          // request_operation_flag of the poll
        logic        queue_empty; // no event queued
        logic [15:0] event_id;    // queued_event_identifier
        logic [31:0] next_handle; // next_chunk_handle
        logic        is_last;     // this chunk ends the event payload
        logic [7:0]  category;    // event_category
        logic [31:0] chunk_len;   // payload bytes to send in this chunk
    } epf_cmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } epf_byte_t;

    typedef enum logic [1:0] {
        EPF_IDLE = 2'b00,
        EPF_HDR  = 2'b01,
        EPF_PAY  = 2'b10,
        EPF_CRC  = 2'b11
    } epf_state_t;

    // reflected crc-32, one byte, lsb first
    function automatic logic [31:0] epf_crc_byte(input logic [31:0] c,
                                                 input logic [7:0]  d);
        logic [31:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < EPF_BYTE_W; i++)
        begin
            fb = r[0] ^ d[i];
            r  = r >> 1;
            if (fb)
                r = r ^ EPF_CRC_POLY_REFL;
        end
        return r;
    endfunction

endpackage

// [epf_framer_chk.sv]
// port assertions for the event poll response framer
`timescale 1ns/100ps
module epf_framer_chk
    import epf_pkg::*;
(
    input wire logic        clk,       // clock
    input wire logic        rst,       // synchronous reset
    input wire logic [31:0] buf_size,  // negotiated buffer size
    input wire logic        cmd_valid, // request offered
    input wire logic        cmd_ready, // request taken
    input wire epf_cmd_t    cmd,       // request fields
    input wire logic [7:0]  pay_data,  // payload byte
    input wire logic        pay_valid, // payload offered
    input wire logic        pay_ready, // payload taken
    input wire logic [7:0]  out_data,  // response byte
    input wire logic        out_last,  // final byte
    input wire logic        out_valid, // byte offered
    input wire logic        out_ready, // byte accepted
    input wire logic        len_err    // oversize pulse
);
    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // -----------------------------------------------------------------
    // sequences
    // -----------------------------------------------------------------
    // an empty buffer at the take edge keeps older bytes out of the way
    sequence s_clean_take;
        cmd_valid && cmd_ready && !out_valid;
    endsequence
    sequence s_null_take;
        s_clean_take ##0 (cmd.queue_empty || cmd.op == EPF_OP_ACK_WITHOUT);
    endsequence
    sequence s_oversize_take;
        s_clean_take ##0 (cmd.op == EPF_OP_FETCH_INITIAL && !cmd.queue_empty
                          && cmd.chunk_len > buf_size);
    endsequence

    // -----------------------------------------------------------------
    // properties
    // -----------------------------------------------------------------
    chk_reset_idle: assert property ($fell(rst) |-> cmd_ready && !out_valid
        && !pay_ready && !len_err)
        else $error("framer not idle after reset");
    chk_empty_id: assert property (s_clean_take ##0 cmd.queue_empty
        |-> ##2 out_valid && out_data == 8'h00)
        else $error("empty queue id byte wrong");
    chk_ack_id: assert property (s_clean_take ##0 !cmd.queue_empty
        ##0 cmd.op == EPF_OP_ACK_WITHOUT |-> ##2 out_valid && out_data == 8'hFF)
        else $error("ack-only id byte wrong");
    chk_null_short: assert property (s_null_take ##2 (out_valid && out_ready)
        |=> out_valid && out_last)
        else $error("null response longer than two bytes");
    chk_out_hold: assert property (out_valid && !out_ready
        |=> out_valid && $stable(out_data) && $stable(out_last))
        else $error("offered byte changed before taken");
    chk_err_cause: assert property (s_oversize_take |=> len_err)
        else $error("oversize chunk not refused");
    chk_err_silent: assert property (s_oversize_take |-> ##1 !out_valid ##1 !out_valid)
        else $error("oversize chunk produced output");
    chk_err_pulse: assert property (len_err |=> !len_err)
        else $error("error pulse longer than one cycle");
    chk_pay_idle: assert property (cmd_ready |-> !pay_ready)
        else $error("payload taken while idle");
endmodule

bind epf_framer epf_framer_chk epf_framer_chk_inst (.clk(clk), .rst(rst), .buf_size(buf_size),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .pay_data(pay_data),
    .pay_valid(pay_valid), .pay_ready(pay_ready), .out_data(out_data), .out_last(out_last),
    .out_valid(out_valid), .out_ready(out_ready), .len_err(len_err));

// [epf_poller_model.sv]
// poller-side model: takes response bytes promptly, slowly or after a long stall
`timescale 1ns/100ps
module epf_poller_model
    import epf_pkg::*;
(
    input  wire logic       clk,       // clock
    input  wire logic       rst,       // synchronous reset
    input  wire logic [1:0] mode,      // 0 prompt, 1 every other cycle, 2 stall 12
    input  wire logic [7:0] out_data,  // response byte
    input  wire logic       out_last,  // final byte
    input  wire logic       out_valid, // byte offered
    output logic            out_ready  // byte accepted
);
    epf_byte_t got[$];
    int        frames;
    int        hold;
    initial
    begin
        out_ready = 1'b0;
        frames    = 0;
        hold      = 0;
    end
    always @(posedge clk)
    begin
        if (!rst && out_valid && out_ready)
        begin
            got.push_back('{data: out_data, last: out_last});
            if (out_last)
            begin
                frames = frames + 1;
                hold   = 0;
            end
        end
        if (mode == 2'h2 && out_valid && hold < 12)
            hold = hold + 1;
        out_ready <= #1 !rst && (mode == 2'h0 || (mode == 2'h1 && !out_ready) || hold >= 12);
    end
endmodule

// [testbench.sv]
// self-checking bench for the event poll response framer
`timescale 1ns/100ps
module testbench
    import epf_pkg::*;
;
    typedef struct packed {
        logic [7:0]  op;
        logic        qe;
        logic [15:0] id;
        logic        last;
        logic [7:0]  len;
        logic [8:0]  bsz;
        logic [1:0]  mode;
        logic [7:0]  flag;
        logic        err;
    } epf_row_t;

    // -----------------------------------------------------------------
    // rows: op, empty, id, last, len, buffer, partner mode, flag, error
    // -----------------------------------------------------------------
    epf_row_t rows [13] = '{
        '{8'h01, 1'b1, 16'h0000, 1'b1, 8'h00, 9'h100, 2'h0, 8'h00, 1'b0},
        '{8'h02, 1'b0, 16'h0005, 1'b1, 8'h00, 9'h100, 2'h0, 8'h00, 1'b0},
        '{8'h01, 1'b0, 16'h1234, 1'b1, 8'h03, 9'h100, 2'h0, 8'h05, 1'b0},
        '{8'h01, 1'b0, 16'h0042, 1'b0, 8'h04, 9'h100, 2'h1, 8'h00, 1'b0},
        '{8'h00, 1'b0, 16'h0042, 1'b0, 8'h02, 9'h100, 2'h0, 8'h01, 1'b0},
        '{8'h00, 1'b0, 16'h0042, 1'b1, 8'h03, 9'h100, 2'h0, 8'h04, 1'b0},
        '{8'h01, 1'b0, 16'h0077, 1'b0, 8'h04, 9'h008, 2'h0, 8'h00, 1'b0},
        '{8'h00, 1'b0, 16'h0077, 1'b1, 8'h05, 9'h008, 2'h0, 8'h01, 1'b0},
        '{8'h00, 1'b0, 16'h0077, 1'b1, 8'h07, 9'h008, 2'h0, 8'h04, 1'b0},
        '{8'h01, 1'b0, 16'h0099, 1'b1, 8'h09, 9'h008, 2'h0, 8'h00, 1'b1},
        '{8'h01, 1'b0, 16'h0099, 1'b1, 8'h08, 9'h008, 2'h2, 8'h05, 1'b0},
        '{8'h01, 1'b0, 16'h00AB, 1'b0, 8'h02, 9'h008, 2'h0, 8'h00, 1'b0},
        '{8'h00, 1'b0, 16'h00AB, 1'b1, 8'h04, 9'h008, 2'h1, 8'h04, 1'b0}};

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] buf_size = 32'h0000_0100;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    epf_cmd_t cmd = '0;
    logic [7:0] pay_data = 8'h00;
    logic pay_valid = 1'b0;
    logic pay_ready;
    logic [7:0] out_data;
    logic out_last;
    logic out_valid;
    logic out_ready;
    logic len_err;
    logic [1:0] mode = 2'h0;
    int miscompares = 0;
    int total_checks = 0;
    logic [31:0] crc;
    logic pend = 1'b0;
    epf_byte_t exp_q[$];

    always #50 clk = ~clk;

    epf_framer epf_framer_inst (.clk(clk), .rst(rst), .buf_size(buf_size),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .pay_data(pay_data),
        .pay_valid(pay_valid), .pay_ready(pay_ready), .out_data(out_data),
        .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready), .len_err(len_err));
    epf_poller_model epf_poller_model_inst (.clk(clk), .rst(rst), .mode(mode),
        .out_data(out_data), .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready));

    // -----------------------------------------------------------------
    // reporting and compare tasks
    // -----------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic timed_out;
        miscompares++;
        final_report();
    endtask
    task automatic check_byte(input epf_byte_t got, input epf_byte_t exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_byte({8'h00, got}, {8'h00, exp});
    endtask
    task automatic push_le(input logic [31:0] v, input int nb);
        for (int b = 0; b < nb; b++)
            exp_q.push_back('{data: v[8*b +: 8], last: 1'b0});
    endtask

    // -----------------------------------------------------------------
    // one response: expectation, request, payload, comparison
    // -----------------------------------------------------------------
    task automatic run_row(input epf_row_t r, input logic [7:0] k);
        logic nul;
        logic crc_only;
        logic [7:0] n;
        logic [7:0] d;
        int f0;
        int t;
        nul = r.qe || r.op == EPF_OP_ACK_WITHOUT;
        crc_only = !nul && pend && r.op == EPF_OP_FETCH_FOLLOWING;
        n = (nul || crc_only || r.err) ? 8'h00 : r.len;
        exp_q.delete();
        epf_poller_model_inst.got.delete();
        f0 = epf_poller_model_inst.frames;
        // crc preset only for a chunk that is really sent
        if (!nul && !r.err && r.op == EPF_OP_FETCH_INITIAL)
            crc = 32'hFFFF_FFFF;
        push_le(nul ? {16'h0000, {16{!r.qe}}} : {16'h0000, r.id}, 2);
        if (!nul)
        begin
            push_le({16'hA5A5, 8'h00, k}, 4);
            push_le({24'h00_0000, r.flag}, 1);
            push_le({24'h00_0000, 8'h10 + k}, 1);
            push_le({24'h00_0000, n}, 4);
            for (int i = 0; i < n; i++)
            begin
                d = {k[3:0], i[3:0]};
                push_le({24'h00_0000, d}, 1);
                for (int b = 0; b < 8; b++)
                    crc = (crc >> 1) ^ ((crc[0] ^ d[b]) ? 32'hEDB8_8320 : 32'h0000_0000);
            end
            if (r.flag == EPF_POS_FINAL)
                push_le(~crc, 4);
            if (!r.err)
                pend = r.last && r.flag == EPF_POS_MIDDLE;
        end
        exp_q[exp_q.size() - 1].last = 1'b1;
        buf_size = {23'h00_0000, r.bsz};
        mode = r.mode;
        cmd = '{op: r.op, queue_empty: r.qe, event_id: r.id, next_handle: {16'hA5A5, 8'h00, k},
                is_last: r.last, category: 8'h10 + k, chunk_len: {24'h00_0000, r.len}};
        cmd_valid = 1'b1;
        for (t = 0; t < 100 && !cmd_ready; t++)
            @(posedge clk) #1;
        if (!cmd_ready)
            timed_out();
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        check_bit(len_err, r.err);
        if (r.err)
        begin
            repeat (4) @(posedge clk);
            #1;
            check_bit(epf_poller_model_inst.got.size() == 0, 1'b1);
            return;
        end
        if (r.mode == 2'h2)
        begin
            repeat (6) @(posedge clk);
            #1;
            check_bit(out_valid && !cmd_ready && epf_poller_model_inst.got.size() == 0, 1'b1);
        end
        for (int i = 0; i < n; i++)
        begin
            pay_data = {k[3:0], i[3:0]};
            pay_valid = 1'b1;
            for (t = 0; t < 100 && !pay_ready; t++)
                @(posedge clk) #1;
            if (!pay_ready)
                timed_out();
            @(posedge clk) #1;
        end
        pay_valid = 1'b0;
        for (t = 0; t < 300 && epf_poller_model_inst.frames == f0; t++)
            @(posedge clk) #1;
        if (epf_poller_model_inst.frames == f0)
            timed_out();
        for (int i = 0; i < exp_q.size(); i++)
            check_byte(epf_poller_model_inst.got[i], exp_q[i]);
        check_bit(epf_poller_model_inst.got.size() == exp_q.size(), 1'b1);
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int r = 0; r < 13; r++)
            run_row(rows[r], r[7:0]);
        // reset in mid-response must leave a clean idle framer
        cmd = '{op: 8'h01, queue_empty: 1'b0, event_id: 16'h0042, next_handle: 32'h0,
                is_last: 1'b0, category: 8'h00, chunk_len: 32'h0000_0004};
        cmd_valid = 1'b1;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        pend = 1'b0;
        check_bit(cmd_ready && !out_valid && !pay_ready, 1'b1);
        run_row(rows[2], 8'h0C);
        final_report();
    end
endmodule
